/* File: compare_skip_branch_unit.sv */
// Compare, skip and branch execution with program counter and status flags
//
// Operation
// - Compares subtract, set ZNVSCH, keep operand, one clock
// - Register bit clear skips next instruction
// - Register bit set skips next instruction
// - I/O bit clear skips next instruction
// - I/O bit set skips next instruction
// - Selected status bit set branches PC+k+1
// - Selected status bit clear branches PC+k+1
// - Carry flag branches set / clear
// - Same-or-higher on C=0, lower on C=1
// - Signed branches test N xor V
// - Half-carry flag branches set / clear
// - T flag branches set / clear
// - Overflow flag branches set / clear
// - Interrupt enable flag branches enabled / disabled
`timescale 1ns/100ps
module compare_skip_branch_unit #(
  parameter int PC_WIDTH = csb_pkg::PC_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Instruction issue
  input wire logic instr_valid,
  input csb_pkg::instr_t instr,
  output logic instr_ready,
  // Status register access from the rest of the core
  input wire logic status_wr,
  input wire logic [7:0] status_wdata,
  output logic [7:0] status_register,
  // Program counter
  output logic [PC_WIDTH-1:0] pc,
  // Completion
  output logic done,
  output logic [1:0] clocks_used
);
  import csb_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01
  } state_t;

  // Control group
  state_t state_q, state_d;
  logic [1:0] wait_q, wait_d;
  logic [1:0] used_q, used_d;
  logic done_q, done_d;

  // Program counter group
  logic [PC_WIDTH-1:0] pc_q, pc_d;

  // Status group
  logic [7:0] status_q, status_d;

  // Decode and target results
  cmp_flags_t cflags;
  logic take;
  logic cmp_now;
  logic is_cmp;
  logic is_cmpc;
  logic cond;
  logic is_branch;
  logic is_skip;
  logic skip_now;
  logic branch_now;
  logic [PC_WIDTH-1:0] pc_next;
  logic [PC_WIDTH-1:0] pc_skip;
  logic [PC_WIDTH-1:0] pc_branch;

  // Sign extension of the relative offset
  function automatic logic [PC_WIDTH-1:0] sext(input logic [6:0] k);
    sext = {{(PC_WIDTH-7){k[6]}}, k};
  endfunction : sext

  // Address step; wraps silently at the top of program space
  function automatic logic [PC_WIDTH-1:0] step(input logic [PC_WIDTH-1:0] p,
    input logic [PC_WIDTH-1:0] n);
    step = p + n;
  endfunction : step

  // Bit picker shared by skips and generic flag branches
  function automatic logic pick(input logic [7:0] v, input logic [2:0] b);
    pick = v[b];
  endfunction : pick

  // Flags come back the same cycle; the difference itself is dropped
  compare_sub u_cmp (
    .opa(instr.opa),
    .opb(instr.opb),
    .carry_in(status_q[FLAG_C]),
    .use_carry(is_cmpc),
    .z_in(status_q[FLAG_Z]),
    .flags(cflags)
  );

  // Only an idle unit accepts; a held request is not queued
  assign take = instr_valid && instr_ready;
  assign cmp_now = take && is_cmp;

  // Condition decode per operation
  always_comb begin
    cond = 1'b0;
    is_branch = 1'b1;
    is_skip = 1'b0;
    is_cmp = 1'b0;
    is_cmpc = 1'b0;
    unique case (instr.op)
      OP_COMPARE_REGS, OP_COMPARE_REG_IMMEDIATE, OP_COMPARE_REGS_WITH_CARRY: begin
        is_cmp = 1'b1;
        is_cmpc = (instr.op == OP_COMPARE_REGS_WITH_CARRY);
        is_branch = 1'b0;
      end
      OP_SKIP_IF_REG_BIT_CLEAR: begin
        is_skip = 1'b1;
        is_branch = 1'b0;
        cond = ~pick(instr.opa, instr.bit_sel);
      end
      OP_SKIP_IF_REG_BIT_SET: begin
        is_skip = 1'b1;
        is_branch = 1'b0;
        cond = pick(instr.opa, instr.bit_sel);
      end
      OP_SKIP_IF_IO_BIT_CLEAR: begin
        is_skip = 1'b1;
        is_branch = 1'b0;
        cond = ~pick(instr.opa, instr.bit_sel);
      end
      OP_SKIP_IF_IO_BIT_SET: begin
        is_skip = 1'b1;
        is_branch = 1'b0;
        cond = pick(instr.opa, instr.bit_sel);
      end
      OP_BRANCH_IF_FLAG_SET: cond = pick(status_q, instr.bit_sel);
      OP_BRANCH_IF_FLAG_CLEAR: cond = ~pick(status_q, instr.bit_sel);
      OP_BRANCH_IF_EQUAL: cond = status_q[FLAG_Z];
      OP_BRANCH_IF_NOT_EQUAL: cond = ~status_q[FLAG_Z];
      OP_BRANCH_IF_CARRY_SET: cond = status_q[FLAG_C];
      OP_BRANCH_IF_CARRY_CLEAR: cond = ~status_q[FLAG_C];
      OP_BRANCH_IF_SAME_OR_HIGHER: cond = ~status_q[FLAG_C];
      OP_BRANCH_IF_LOWER: cond = status_q[FLAG_C];
      OP_BRANCH_IF_MINUS: cond = status_q[FLAG_N];
      OP_BRANCH_IF_PLUS: cond = ~status_q[FLAG_N];
      OP_BRANCH_IF_GREATER_EQUAL: cond = ~(status_q[FLAG_N] ^ status_q[FLAG_V]);
      OP_BRANCH_IF_LESS_THAN: cond = status_q[FLAG_N] ^ status_q[FLAG_V];
      OP_BRANCH_IF_HALF_CARRY_SET: cond = status_q[FLAG_H];
      OP_BRANCH_IF_HALF_CARRY_CLEAR: cond = ~status_q[FLAG_H];
      OP_BRANCH_IF_T_SET: cond = status_q[FLAG_T];
      OP_BRANCH_IF_T_CLEAR: cond = ~status_q[FLAG_T];
      OP_BRANCH_IF_OVERFLOW_SET: cond = status_q[FLAG_V];
      OP_BRANCH_IF_OVERFLOW_CLEAR: cond = ~status_q[FLAG_V];
      OP_BRANCH_IF_IRQ_ENABLED: cond = status_q[FLAG_I];
      OP_BRANCH_IF_IRQ_DISABLED: cond = ~status_q[FLAG_I];
      // Unlisted codes are neither skips nor branches
      default: is_branch = 1'b0;
    endcase
  end

  // Target addresses for the three ways out of an instruction
  always_comb begin
    pc_next = step(pc_q, PC_WIDTH'(1));
    pc_skip = instr.next_two_word ? step(pc_q, PC_WIDTH'(3)) : step(pc_q, PC_WIDTH'(2));
    pc_branch = step(pc_next, sext(instr.offset));
    skip_now = is_skip && cond;
    branch_now = is_branch && cond;
  end

  // Control next state; done pulses on the last clock of every instruction
  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    used_d = used_q;
    done_d = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (take) begin
          used_d = CLK_ONE;
          done_d = 1'b1;
          if (skip_now) begin
            used_d = instr.next_two_word ? CLK_THREE : CLK_TWO;
            wait_d = instr.next_two_word ? CLK_TWO : CLK_ONE;
            done_d = 1'b0;
            state_d = ST_WAIT;
          end else if (branch_now) begin
            used_d = CLK_TWO;
            wait_d = CLK_ONE;
            done_d = 1'b0;
            state_d = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        // Extra clocks burn down; issue stays stalled meanwhile
        wait_d = wait_q - 2'h1;
        if (wait_q == 2'h1) begin
          state_d = ST_IDLE;
          done_d = 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_comb begin
    pc_d = pc_q;
    if (take) begin
      if (skip_now) begin
        pc_d = pc_skip;
      end else if (branch_now) begin
        pc_d = pc_branch;
      end else begin
        pc_d = pc_next;
      end
    end
  end

  // Status next value
  always_comb begin
    status_d = status_q;
    // Core writes lose C, Z, N, V, S and H to a compare in the same cycle; the compare is newer
    if (status_wr) begin
      status_d = status_wdata;
    end
    if (cmp_now) begin
      status_d[FLAG_C] = cflags.c;
      status_d[FLAG_Z] = cflags.z;
      status_d[FLAG_N] = cflags.n;
      status_d[FLAG_V] = cflags.v;
      status_d[FLAG_S] = cflags.s;
      status_d[FLAG_H] = cflags.h;
    end
  end

  // Control registers
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      wait_q <= 2'h0;
      used_q <= 2'h0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      used_q <= used_d;
      done_q <= done_d;
    end
  end

  // Program counter register
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_q <= PC_WIDTH'(PC_RESET);
    end else begin
      pc_q <= pc_d;
    end
  end

  // Status register
  always_ff @(posedge clk) begin
    if (srst) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // Stalls issue while a skip or taken branch burns its extra clocks
  assign instr_ready = (state_q == ST_IDLE);
  assign status_register = status_q;
  assign pc = pc_q;
  assign done = done_q;
  assign clocks_used = used_q;
endmodule : compare_skip_branch_unit

/* File: compare_skip_branch_unit_tb_top.sv */
// Self-checking testbench for the compare/skip/branch unit
`timescale 1ns/100ps
module compare_skip_branch_unit_tb_top;
  import csb_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic instr_valid = 1'b0;
  instr_t instr = '0;
  logic status_wr = 1'b0;
  logic [7:0] status_wdata = 8'h00;
  logic instr_ready;
  logic [7:0] status_register;
  logic [11:0] pc;
  logic done;
  logic [1:0] clocks_used;
  int error_cnt = 0;
  int comparisons = 0;

  always #12.5 clk = ~clk;

  compare_skip_branch_unit dut (.clk(clk), .srst(srst), .instr_valid(instr_valid),
    .instr(instr), .instr_ready(instr_ready), .status_wr(status_wr),
    .status_wdata(status_wdata),
    .status_register(status_register), .pc(pc), .done(done), .clocks_used(clocks_used));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  function automatic instr_t mk(input op_t o, input logic [7:0] a, input logic [7:0] b,
    input logic [2:0] s, input logic [6:0] k, input logic w);
    return '{o, a, b, s, k, w};
  endfunction : mk

  task automatic do_reset;
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    #1;
    check("pc", pc, 0);
    check("flags", status_register, 0);
    check("clocks", clocks_used, 0);
    check("done", done, 0);
    check("ready", instr_ready, 1);
  endtask : do_reset

  task automatic setsr(input logic [7:0] v);
    @(posedge clk);
    status_wr <= 1'b1;
    status_wdata <= v;
    @(posedge clk);
    status_wr <= 1'b0;
  endtask : setsr

  task automatic issue(input instr_t i, input logic [1:0] n, output logic [11:0] p0);
    int c;
    // Start address read while the counter is settled
    p0 = pc;
    @(posedge clk);
    instr <= i;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    c = 1;
    #1;
    while (done !== 1'b1 && c < 4) begin
      @(posedge clk);
      #1;
      c++;
    end
    check("cycles", c, n);
    check("clocks", clocks_used, n);
  endtask : issue

  task automatic test_compare;
    op_t o[5] = '{OP_COMPARE_REGS, OP_COMPARE_REG_IMMEDIATE, OP_COMPARE_REGS,
      OP_COMPARE_REGS_WITH_CARRY, OP_COMPARE_REGS_WITH_CARRY};
    logic [7:0] a[5] = '{8'h10, 8'h10, 8'h80, 8'h05, 8'h05};
    logic [7:0] b[5] = '{8'h10, 8'h20, 8'h01, 8'h04, 8'h04};
    logic [7:0] s[5] = '{8'hc1, 8'h00, 8'h40, 8'h03, 8'h01};
    logic [8:0] d;
    logic [4:0] h;
    logic ci;
    logic [7:0] e;
    logic [11:0] p0;
    for (int i = 0; i < 5; i++) begin
      setsr(s[i]);
      ci = (o[i] == OP_COMPARE_REGS_WITH_CARRY) && s[i][FLAG_C];
      d = {1'b0, a[i]} - {1'b0, b[i]} - 9'(ci);
      h = {1'b0, a[i][3:0]} - {1'b0, b[i][3:0]} - 5'(ci);
      e = s[i];
      e[FLAG_C] = d[8];
      // Carry form keeps Z only if it was already set
      e[FLAG_Z] = d[7:0] == 8'h00 && (o[i] != OP_COMPARE_REGS_WITH_CARRY || s[i][FLAG_Z]);
      e[FLAG_N] = d[7];
      e[FLAG_V] = (a[i][7] != b[i][7]) && (d[7] != a[i][7]);
      e[FLAG_S] = e[FLAG_N] ^ e[FLAG_V];
      e[FLAG_H] = h[4];
      issue(mk(o[i], a[i], b[i], 3'h0, 7'h00, 1'b0), CLK_ONE, p0);
      check("cmp flags", status_register, e);
      check("cmp pc", pc, p0 + 12'h1);
    end
  endtask : test_compare

  function automatic logic taken(input int c, input logic [7:0] s, input logic [2:0] b);
    logic f;
    case (c / 2)
      4: f = s[b];
      5: f = s[FLAG_Z];
      6, 7: f = s[FLAG_C];
      8: f = s[FLAG_N];
      9: f = s[FLAG_N] ^ s[FLAG_V];
      10: f = s[FLAG_H];
      11: f = s[FLAG_T];
      12: f = s[FLAG_V];
      default: f = s[FLAG_I];
    endcase
    // Same-or-higher and greater-equal branch on the cleared test
    return f ^ c[0] ^ (c / 2 == 7 || c / 2 == 9);
  endfunction : taken

  task automatic test_branch;
    logic [7:0] s[3] = '{8'h00, 8'hff, 8'h08};
    logic [6:0] k;
    logic [11:0] p0;
    logic [11:0] e;
    logic t;
    for (int j = 0; j < 3; j++) begin
      setsr(s[j]);
      for (int c = 8; c < 28; c++) begin
        k = {c[0], 6'h05};
        t = taken(c, s[j], 3'(c + j));
        issue(mk(op_t'(c), 8'h00, 8'h00, 3'(c + j), k, 1'b0), t ? CLK_TWO : CLK_ONE, p0);
        e = t ? p0 + {{5{k[6]}}, k} + 12'h1 : p0 + 12'h1;
        check("br pc", pc, e);
        check("br flags", status_register, s[j]);
      end
    end
  endtask : test_branch

  task automatic test_skip;
    logic sk;
    logic [11:0] p0;
    setsr(8'ha5);
    for (int c = 4; c < 8; c++) begin
      for (int m = 0; m < 4; m++) begin
        sk = m[0] == c[0];
        issue(mk(op_t'(c), m[0] ? 8'h08 : 8'hf7, 8'h00, 3'h3, 7'h00, m[1]),
          sk ? 2'(2 + m[1]) : CLK_ONE, p0);
        check("skip pc", pc, p0 + (sk ? 12'(2 + m[1]) : 12'h1));
        check("skip flags", status_register, 8'ha5);
      end
    end
  endtask : test_skip

  // Valid held through a taken branch is taken once only
  task automatic test_refuse;
    logic [11:0] p0;
    setsr(8'h02);
    p0 = pc;
    @(posedge clk);
    instr <= mk(OP_BRANCH_IF_EQUAL, 8'h00, 8'h00, 3'h0, 7'h03, 1'b0);
    instr_valid <= 1'b1;
    @(posedge clk);
    #1;
    check("ready", instr_ready, 0);
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    check("ready", instr_ready, 1);
    check("done", done, 1);
    check("refused pc", pc, p0 + 12'h4);
  endtask : test_refuse

  initial begin
    do_reset();
    test_compare();
    test_branch();
    test_skip();
    test_refuse();
    do_reset();
    final_report();
  end

  // Run needs well under 1000 cycles; 4000 leaves margin
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end
endmodule : compare_skip_branch_unit_tb_top

/* File: compare_sub.sv */
// Flag-only subtractor for the compare operations
`timescale 1ns/100ps
module compare_sub (
  // Operands
  input wire logic [7:0] opa,
  input wire logic [7:0] opb,
  input wire logic carry_in,
  input wire logic use_carry,
  input wire logic z_in,
  // Flags
  output csb_pkg::cmp_flags_t flags
);
  import csb_pkg::*;
  logic [8:0] diff;
  logic [7:0] res;
  logic cin;
  always_comb begin
    cin = use_carry & carry_in;
    diff = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
    res = diff[7:0];
    flags.c = diff[8];
    flags.n = res[7];
    flags.v = (opa[7] & ~opb[7] & ~res[7]) | (~opa[7] & opb[7] & res[7]);
    flags.s = flags.n ^ flags.v;
    flags.h = (~opa[3] & opb[3]) | (opb[3] & res[3]) | (res[3] & ~opa[3]);
    // Compare with carry keeps Z set only while the whole chain is zero
    flags.z = use_carry ? ((res == 8'h00) & z_in) : (res == 8'h00);
  end
endmodule : compare_sub

/* File: csb_checker.sv */
// Port-level assertions for the compare/skip/branch unit
`timescale 1ns/100ps
module csb_checker #(
  parameter int PC_WIDTH = csb_pkg::PC_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Issue
  input wire logic instr_valid,
  input csb_pkg::instr_t instr,
  input wire logic instr_ready,
  // Status
  input wire logic status_wr,
  input wire logic [7:0] status_wdata,
  input wire logic [7:0] status_register,
  // Results
  input wire logic [PC_WIDTH-1:0] pc,
  input wire logic done,
  input wire logic [1:0] clocks_used
);
  import csb_pkg::*;
  logic tk;
  logic [PC_WIDTH-1:0] inc;
  logic [PC_WIDTH-1:0] tgt;
  assign tk = instr_valid && instr_ready;
  assign inc = pc + 1'b1;
  // Offset is signed, so extend its sign
  assign tgt = inc + {{(PC_WIDTH-7){instr.offset[6]}}, instr.offset};
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  done_when_a: assert property (
    tk |=> done == (clocks_used == CLK_ONE)) else $error("done timing");
  two_clk_a: assert property (
    tk ##1 clocks_used == CLK_TWO |-> !instr_ready ##1 done) else $error("two clock op");
  three_clk_a: assert property (
    tk ##1 clocks_used == CLK_THREE |-> !instr_ready [*2] ##1 done) else $error("three clock op");
  cmp_pc_a: assert property (
    tk && instr.op inside {[OP_COMPARE_REGS:OP_COMPARE_REG_IMMEDIATE]} |=> pc == $past(inc))
    else $error("compare pc");
  cmp_eq_a: assert property (
    tk && instr.op == OP_COMPARE_REGS && instr.opa == instr.opb |=> status_register[1:0] == 2'h2)
    else $error("compare equal flags");
  beq_taken_a: assert property (
    tk && instr.op == OP_BRANCH_IF_EQUAL && status_register[FLAG_Z] |=> pc == $past(tgt))
    else $error("equal branch target");
  bne_fall_a: assert property (
    tk && instr.op == OP_BRANCH_IF_NOT_EQUAL && status_register[FLAG_Z]
    |=> pc == $past(inc) && done) else $error("not equal fall through");
  skip_flags_a: assert property (
    tk && !status_wr && instr.op inside {[OP_SKIP_IF_REG_BIT_CLEAR:OP_SKIP_IF_IO_BIT_SET]}
    |=> $stable(status_register)) else $error("skip changed flags");
  wr_load_a: assert property (
    status_wr && !(tk && instr.op inside {[OP_COMPARE_REGS:OP_COMPARE_REG_IMMEDIATE]})
    |=> status_register == $past(status_wdata)) else $error("status write lost");
  cover property (tk ##1 clocks_used == CLK_TWO);
  cover property (tk ##1 clocks_used == CLK_THREE);
  cover property (tk && instr.op == OP_COMPARE_REGS_WITH_CARRY);
endmodule : csb_checker

bind compare_skip_branch_unit csb_checker #(.PC_WIDTH(PC_WIDTH)) chk (.clk(clk), .srst(srst),
  .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .status_wr(status_wr),
  .status_wdata(status_wdata), .status_register(status_register), .pc(pc), .done(done),
  .clocks_used(clocks_used));

/* File: csb_pkg.sv */
// Package: operation codes, flag positions and carriers for the compare/skip/branch unit
package csb_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 12;
  localparam int OFS_W = 7;
  // Status register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [11:0] PC_RESET = 12'h000;
  // Clock counts
  localparam logic [1:0] CLK_ONE = 2'h1;
  localparam logic [1:0] CLK_TWO = 2'h2;
  localparam logic [1:0] CLK_THREE = 2'h3;

  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_COMPARE_REGS = 5'h01,
    OP_COMPARE_REGS_WITH_CARRY = 5'h02,
    OP_COMPARE_REG_IMMEDIATE = 5'h03,
    OP_SKIP_IF_REG_BIT_CLEAR = 5'h04,
    OP_SKIP_IF_REG_BIT_SET = 5'h05,
    OP_SKIP_IF_IO_BIT_CLEAR = 5'h06,
    OP_SKIP_IF_IO_BIT_SET = 5'h07,
    OP_BRANCH_IF_FLAG_SET = 5'h08,
    OP_BRANCH_IF_FLAG_CLEAR = 5'h09,
    OP_BRANCH_IF_EQUAL = 5'h0a,
    OP_BRANCH_IF_NOT_EQUAL = 5'h0b,
    OP_BRANCH_IF_CARRY_SET = 5'h0c,
    OP_BRANCH_IF_CARRY_CLEAR = 5'h0d,
    OP_BRANCH_IF_SAME_OR_HIGHER = 5'h0e,
    OP_BRANCH_IF_LOWER = 5'h0f,
    OP_BRANCH_IF_MINUS = 5'h10,
    OP_BRANCH_IF_PLUS = 5'h11,
    OP_BRANCH_IF_GREATER_EQUAL = 5'h12,
    OP_BRANCH_IF_LESS_THAN = 5'h13,
    OP_BRANCH_IF_HALF_CARRY_SET = 5'h14,
    OP_BRANCH_IF_HALF_CARRY_CLEAR = 5'h15,
    OP_BRANCH_IF_T_SET = 5'h16,
    OP_BRANCH_IF_T_CLEAR = 5'h17,
    OP_BRANCH_IF_OVERFLOW_SET = 5'h18,
    OP_BRANCH_IF_OVERFLOW_CLEAR = 5'h19,
    OP_BRANCH_IF_IRQ_ENABLED = 5'h1a,
    OP_BRANCH_IF_IRQ_DISABLED = 5'h1b
  } op_t;

  // One instruction as presented by the decoder
  typedef struct packed {
    op_t op;
    logic [7:0] opa;
    logic [7:0] opb;
    logic [2:0] bit_sel;
    logic [6:0] offset;
    logic next_two_word;
  } instr_t;

  // Result flags of a compare
  typedef struct packed {
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } cmp_flags_t;
endpackage : csb_pkg
